// ==== src/clk_ctrl_defs.svh ====
// constants for the clock gating and multiplier control block
`ifndef CLK_CTRL_DEFS_SVH
`define CLK_CTRL_DEFS_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define ADDR_PROC_CLK    4'h0
`define ADDR_MULT_CTRL   4'h1
`define ADDR_PORT_CTRL   4'h2
`define ADDR_PORT_IN     4'h3

// ----------------------------------------
// processor clock control fields
// ----------------------------------------
`define PROC_CLK_RESET   8'h03
`define BIT_SUB_FB_CUT   7
`define BIT_OSC_STOP     6
`define BIT_MAIN_FB_CUT  5
`define BIT_SRC_STATUS   4
`define BIT_SUB_SELECT   3
`define DIV_SEL_MSB      2
`define PROC_CLK_WMASK   8'hEF

// ----------------------------------------
// multiplier control fields
// ----------------------------------------
`define MULT_CTRL_RESET  8'h01
`define MULT_CTRL_WMASK  8'h0F
`define BIT_MULT_RUN     0
`define BIT_MULT_SELECT  1
`define MULT_FACTOR_PLL  3'h4
`define MULT_FACTOR_THRU 3'h1

// ----------------------------------------
// port control fields
// ----------------------------------------
`define PORT_CTRL_RESET  8'h00
`define PORT_CTRL_WMASK  8'h07
`define BIT_PORT_CLKSEL  0
`define BIT_PORT_DATA    1
`define BIT_PORT_DIR     2

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_SYS_MHZ      10
`define OSC_WAIT_US      820
`define OSC_WAIT_CYCLES  (`OSC_WAIT_US * `CLK_SYS_MHZ)
`define DIV_MAX_SEL      3'h5

`endif

// ==== src/clk_ctrl_pkg.sv ====
// types for the clock gating and multiplier control block
package clk_ctrl_pkg;

    // ----------------------------------------
    // operating states, one-hot
    // ----------------------------------------
    typedef enum logic [7:0] {
        ST_RESET    = 8'h01,
        ST_OSC_WAIT = 8'h02,
        ST_NORMAL   = 8'h04,
        ST_HALT     = 8'h08,
        ST_IDLE     = 8'h10,
        ST_STOP     = 8'h20,
        ST_SUB      = 8'h40,
        ST_SUB_IDLE = 8'h80
    } power_state_t;

    typedef logic [7:0] reg_byte_t;
    typedef logic [3:0] reg_addr_t;

endpackage : clk_ctrl_pkg

// ==== src/clock_output_pin_divider.sv ====
// divider producing the clock output pin level
`timescale 1ns/10ps
`include "clk_ctrl_defs.svh"
module clock_output_pin_divider (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       ce,
    // control
    input  wire logic       run,
    input  wire logic       use_sub,
    input  wire logic [2:0] div_sel,
    input  wire logic       sub_edge,
    // output level
    output logic            level
);

    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    logic       level_reg;
    logic       level_next;

    // terminal count for a power-of-two divide, prohibited codes clamped
    function automatic logic [4:0] div_limit(input logic [2:0] sel);
        logic [2:0] s;
        s = (sel > `DIV_MAX_SEL) ? `DIV_MAX_SEL : sel;
        div_limit = 5'(({5'h00, 1'b1} << s) - 6'h01);
    endfunction : div_limit

    wire       term   = use_sub ? sub_edge : (cnt_reg >= div_limit(div_sel));
    // stop only from low so no runt high pulse is cut
    wire       toggle = term & (run | level_reg);

    assign cnt_next   = (term | use_sub) ? 5'h00 : 5'(cnt_reg + 5'h01);
    assign level_next = toggle ? ~level_reg : level_reg;
    assign level      = level_reg;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cnt_reg   <= 5'h00;
            level_reg <= 1'b0;
        end else if (ce) begin
            cnt_reg   <= cnt_next;
            level_reg <= level_next;
        end
    end

endmodule : clock_output_pin_divider

// ==== src/clock_gating_pll_control.sv ====
// clock gating, clock output pin and multiplier control
`timescale 1ns/10ps
`include "clk_ctrl_defs.svh"
module clock_gating_pll_control #(
    parameter int OSC_WAIT_CYCLES = `OSC_WAIT_CYCLES
) (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    input  wire logic                  ce,
    // register port
    input  wire clk_ctrl_pkg::reg_addr_t reg_addr,
    input  wire clk_ctrl_pkg::reg_byte_t reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output clk_ctrl_pkg::reg_byte_t    reg_rdata,
    // standby requests from the cpu
    input  wire logic                  halt_req,
    input  wire logic                  idle_req,
    input  wire logic                  stop_req,
    input  wire logic                  wake_req,
    // subclock oscillator level
    input  wire logic                  subclock_in,
    // oscillator control
    output logic                       main_osc_run,
    output logic                       main_feedback_cut,
    output logic                       sub_feedback_cut,
    // clock gates
    output logic                       cpu_clk_en,
    output logic                       sys_clk_en,
    output logic                       periph_clk_en,
    output logic                       watch_timer_en,
    output logic                       watchdog_one_en,
    output logic                       watchdog_two_en,
    // multiplier
    output logic                       multiplier_run,
    output logic                       multiplier_select,
    output logic [2:0]                 mult_factor,
    // clock output pin
    input  wire logic                  clock_output_pin_i,
    output logic                       clock_output_pin_o,
    output logic                       clock_output_pin_oe,
    // status
    output logic                       clock_source_status
);
    import clk_ctrl_pkg::*;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg_byte_t    proc_clk_reg;
    reg_byte_t    multiplier_control_reg;
    reg_byte_t    port_ctrl_reg;
    reg_byte_t    rdata_reg;
    reg_byte_t    rdata_next;
    power_state_t state_reg;
    power_state_t state_next;
    logic [31:0]  wait_cnt_reg;
    logic [31:0]  wait_cnt_next;
    logic         after_reset_reg;
    logic         src_status_reg;
    logic         osc_run_reg;
    logic         cpu_en_reg;
    logic         sys_en_reg;
    logic         periph_en_reg;
    logic         pin_oe_reg;
    logic         pin_o_reg;
    logic [2:0]   sub_sync_reg;
    logic         sub_level_reg;
    logic [2:0]   pin_sync_reg;
    logic         pin_level_reg;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    // a change counts once the second and third stages agree
    wire sub_stable  = sub_sync_reg[1] == sub_sync_reg[2];
    wire sub_edge    = sub_stable & sub_sync_reg[2] & ~sub_level_reg;
    wire pin_stable  = pin_sync_reg[1] == pin_sync_reg[2];

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            sub_sync_reg  <= 3'h0;
            sub_level_reg <= 1'b0;
            pin_sync_reg  <= 3'h0;
            pin_level_reg <= 1'b0;
        end else if (ce) begin
            sub_sync_reg  <= {sub_sync_reg[1:0], subclock_in};
            pin_sync_reg  <= {pin_sync_reg[1:0], clock_output_pin_i};
            if (sub_stable)
                sub_level_reg <= sub_sync_reg[2];
            if (pin_stable)
                pin_level_reg <= pin_sync_reg[2];
        end
    end

    // ----------------------------------------
    // register fields
    // ----------------------------------------
    wire       osc_stop_bit   = proc_clk_reg[`BIT_OSC_STOP];
    wire       sub_select_bit = proc_clk_reg[`BIT_SUB_SELECT];
    wire [2:0] div_sel        = proc_clk_reg[`DIV_SEL_MSB:0];
    wire       mult_run_bit   = multiplier_control_reg[`BIT_MULT_RUN];
    wire       mult_sel_bit   = multiplier_control_reg[`BIT_MULT_SELECT];
    wire       port_clksel    = port_ctrl_reg[`BIT_PORT_CLKSEL];
    wire       port_data      = port_ctrl_reg[`BIT_PORT_DATA];
    wire       port_dir       = port_ctrl_reg[`BIT_PORT_DIR];

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    wire hit_proc  = reg_addr == `ADDR_PROC_CLK;
    wire hit_mult  = reg_addr == `ADDR_MULT_CTRL;
    wire hit_port  = reg_addr == `ADDR_PORT_CTRL;
    wire hit_pin   = reg_addr == `ADDR_PORT_IN;
    wire wr_proc   = reg_wr & hit_proc;
    wire wr_mult   = reg_wr & hit_mult;
    wire wr_port   = reg_wr & hit_port;

    // source status bit is not writable
    wire [7:0] proc_wval = (reg_wdata & `PROC_CLK_WMASK) |
                           (proc_clk_reg & ~`PROC_CLK_WMASK);
    // upper bits of multiplier control hold zero whatever is written
    wire [7:0] mult_wval = reg_wdata & `MULT_CTRL_WMASK;
    wire [7:0] port_wval = reg_wdata & `PORT_CTRL_WMASK;

    wire [7:0] proc_rval = {proc_clk_reg[7:5], src_status_reg,
                            proc_clk_reg[3:0]};

    always_comb begin
        rdata_next = 8'h00;
        if (reg_rd) begin
            if (hit_proc)
                rdata_next = proc_rval;
            else if (hit_mult)
                rdata_next = multiplier_control_reg;
            else if (hit_port)
                rdata_next = port_ctrl_reg;
            else if (hit_pin)
                rdata_next = {7'h00, pin_level_reg};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            proc_clk_reg           <= `PROC_CLK_RESET;
            // left running in passthrough; software stops it if unused
            multiplier_control_reg <= `MULT_CTRL_RESET;
            port_ctrl_reg          <= `PORT_CTRL_RESET;
            rdata_reg              <= 8'h00;
        end else if (ce) begin
            rdata_reg <= rdata_next;
            if (wr_proc)
                proc_clk_reg <= proc_wval;
            if (wr_mult)
                multiplier_control_reg <= mult_wval;
            if (wr_port)
                port_ctrl_reg <= port_wval;
        end
    end

    assign reg_rdata = rdata_reg;

    // ----------------------------------------
    // operating state
    // ----------------------------------------
    wire in_reset  = state_reg == ST_RESET;
    wire in_wait   = state_reg == ST_OSC_WAIT;
    wire in_normal = state_reg == ST_NORMAL;
    wire in_sub    = state_reg == ST_SUB;
    wire wait_done = wait_cnt_reg == 32'h0;
    // source switches take effect on a subclock edge
    wire to_sub    = in_normal & sub_select_bit & sub_edge;
    wire to_main   = in_sub & ~sub_select_bit & sub_edge;

    always_comb begin
        state_next    = state_reg;
        wait_cnt_next = wait_done ? 32'h0 : 32'(wait_cnt_reg - 32'h1);
        case (state_reg)
            ST_RESET: begin
                // wait is inserted whatever drives the oscillator
                state_next    = ST_OSC_WAIT;
                wait_cnt_next = 32'(OSC_WAIT_CYCLES);
            end
            ST_OSC_WAIT: begin
                if (wait_done)
                    state_next = ST_NORMAL;
            end
            ST_NORMAL: begin
                // software has put the multiplier in passthrough first
                if (stop_req)
                    state_next = ST_STOP;
                else if (idle_req)
                    state_next = ST_IDLE;
                else if (halt_req)
                    state_next = ST_HALT;
                else if (to_sub)
                    state_next = ST_SUB;
            end
            ST_HALT: begin
                if (wake_req)
                    state_next = ST_NORMAL;
            end
            ST_IDLE: begin
                if (wake_req)
                    state_next = ST_NORMAL;
            end
            ST_STOP: begin
                if (wake_req) begin
                    state_next    = ST_OSC_WAIT;
                    wait_cnt_next = 32'(OSC_WAIT_CYCLES);
                end
            end
            ST_SUB: begin
                if (idle_req)
                    state_next = ST_SUB_IDLE;
                else if (to_main)
                    state_next = ST_NORMAL;
            end
            ST_SUB_IDLE: begin
                if (wake_req)
                    state_next = ST_SUB;
            end
            default: begin
                state_next = ST_RESET;
            end
        endcase
    end

    // ----------------------------------------
    // gate decisions for the next state
    // ----------------------------------------
    wire n_reset    = state_next == ST_RESET;
    wire n_stop     = state_next == ST_STOP;
    wire n_normal   = state_next == ST_NORMAL;
    wire n_halt     = state_next == ST_HALT;
    wire n_sub_cpu  = (state_next == ST_SUB) |
                      (state_next == ST_SUB_IDLE);
    wire n_sub_run  = state_next == ST_SUB;
    // stop bit only bites once the cpu runs from the subclock
    wire n_osc_stop = osc_stop_bit & n_sub_cpu;
    wire n_osc_run  = ~n_reset & ~n_stop & ~n_osc_stop;
    wire n_cpu_en   = n_normal | n_sub_run;
    wire n_sys_en   = n_normal | n_halt | n_sub_run;
    wire n_per_en   = n_normal | n_halt |
                      (n_sub_run & ~osc_stop_bit);

    // gates change only on the clock edge so no partial pulse passes
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_reg       <= ST_RESET;
            wait_cnt_reg    <= 32'h0;
            after_reset_reg <= 1'b1;
            src_status_reg  <= 1'b0;
            osc_run_reg     <= 1'b0;
            cpu_en_reg      <= 1'b0;
            sys_en_reg      <= 1'b0;
            periph_en_reg   <= 1'b0;
        end else if (ce) begin
            state_reg      <= state_next;
            wait_cnt_reg   <= wait_cnt_next;
            src_status_reg <= n_sub_cpu;
            osc_run_reg    <= n_osc_run;
            cpu_en_reg     <= n_cpu_en;
            sys_en_reg     <= n_sys_en;
            periph_en_reg  <= n_per_en;
            if (in_wait & wait_done)
                after_reset_reg <= 1'b0;
        end
    end

    assign main_osc_run        = osc_run_reg;
    assign watch_timer_en      = osc_run_reg;
    assign watchdog_one_en     = osc_run_reg;
    assign cpu_clk_en          = cpu_en_reg;
    assign sys_clk_en          = sys_en_reg;
    assign periph_clk_en       = periph_en_reg;
    assign watchdog_two_en     = periph_en_reg;
    assign clock_source_status = src_status_reg;
    // feedback cut is software's to set for a driven input pair
    assign main_feedback_cut   = proc_clk_reg[`BIT_MAIN_FB_CUT];
    assign sub_feedback_cut    = proc_clk_reg[`BIT_SUB_FB_CUT];

    // ----------------------------------------
    // multiplier
    // ----------------------------------------
    // selection only honoured while running, relying on the
    // lock and deselect waits being kept by software
    wire mult_engaged = mult_run_bit & mult_sel_bit;

    assign multiplier_run    = mult_run_bit;
    assign multiplier_select = mult_engaged;
    assign mult_factor       = mult_engaged ? `MULT_FACTOR_PLL :
                                              `MULT_FACTOR_THRU;

    // ----------------------------------------
    // clock output pin
    // ----------------------------------------
    logic clk_level;

    clock_output_pin_divider u_div (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .ce       (ce),
        .run      (sys_en_reg),
        .use_sub  (sub_select_bit),
        .div_sel  (div_sel),
        .sub_edge (sub_edge),
        .level    (clk_level)
    );

    // floating pin through reset and the following wait
    wire pin_float = in_reset | (in_wait & after_reset_reg);
    wire pin_oe_nx = ~pin_float & (port_clksel | port_dir);
    wire pin_o_nx  = port_clksel ? clk_level : port_data;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pin_oe_reg <= 1'b0;
            pin_o_reg  <= 1'b0;
        end else if (ce) begin
            pin_oe_reg <= pin_oe_nx;
            pin_o_reg  <= pin_float ? 1'b0 : pin_o_nx;
        end
    end

    assign clock_output_pin_oe = pin_oe_reg;
    assign clock_output_pin_o  = pin_o_reg;

endmodule : clock_gating_pll_control

// ==== sim/clk_ctrl_monitor.sv ====
// checker bound to the clock gating and multiplier control block
`timescale 1ns/10ps
module clk_ctrl_monitor #(
    parameter int OSC_WAIT_CYCLES = 20
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       ce,
    // standby requests
    input  wire logic       halt_req,
    input  wire logic       idle_req,
    input  wire logic       stop_req,
    input  wire logic       wake_req,
    // gates
    input  wire logic       main_osc_run,
    input  wire logic       cpu_clk_en,
    input  wire logic       sys_clk_en,
    input  wire logic       periph_clk_en,
    input  wire logic       watch_timer_en,
    input  wire logic       watchdog_one_en,
    input  wire logic       watchdog_two_en,
    // multiplier, pin and status
    input  wire logic       multiplier_run,
    input  wire logic       multiplier_select,
    input  wire logic [2:0] mult_factor,
    input  wire logic       clock_output_pin_oe,
    input  wire logic       clock_source_status
);
    localparam int WAIT_LO = OSC_WAIT_CYCLES;
    localparam int WAIT_HI = OSC_WAIT_CYCLES + 4;
    logic ran_reg;
    // ----------------------------------------
    // helper: first start-up wait is over
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ran_reg <= 1'b0;
        end else if (sys_clk_en) begin
            ran_reg <= 1'b1;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    a_reset_outputs: assert property (
        $rose(resetn) |-> !main_osc_run && !sys_clk_en && multiplier_run &&
            !multiplier_select && !clock_output_pin_oe && mult_factor == 3'h1
    ) else $error("outputs wrong after reset");
    a_startup_wait: assert property (
        $rose(resetn) |-> ##[WAIT_LO:WAIT_HI] $rose(sys_clk_en)
    ) else $error("start-up wait length wrong");
    a_stop_wait: assert property (
        ce && ran_reg && wake_req && !main_osc_run && !clock_source_status
            |-> ##[WAIT_LO:WAIT_HI] $rose(sys_clk_en)
    ) else $error("wait after stop wrong");
    a_cpu_needs_sys: assert property (
        cpu_clk_en |-> sys_clk_en
    ) else $error("cpu clock without system clock");
    a_periph_needs_osc: assert property (
        periph_clk_en |-> main_osc_run && sys_clk_en
    ) else $error("peripheral clock without oscillator");
    a_mult_factor: assert property (
        (multiplier_select |-> multiplier_run) and
            mult_factor == (multiplier_select ? 3'h4 : 3'h1)
    ) else $error("multiplier factor wrong");
    a_halt_cpu_off: assert property (
        ce && halt_req && !idle_req && !stop_req && cpu_clk_en &&
            !clock_source_status |=> !cpu_clk_en && sys_clk_en && periph_clk_en
    ) else $error("halt gating wrong");
    a_idle_gates_off: assert property (
        ce && (idle_req || stop_req) && cpu_clk_en && !clock_source_status
            |=> !cpu_clk_en && !sys_clk_en && !periph_clk_en
    ) else $error("idle gating wrong");
    a_stop_osc_off: assert property (
        ce && stop_req && cpu_clk_en && !clock_source_status |=> !main_osc_run
    ) else $error("oscillator runs in stop");
    a_osc_stop_sub: assert property (
        $fell(main_osc_run) |-> clock_source_status || !sys_clk_en
    ) else $error("oscillator stopped on main clock");
    a_wd_follow: assert property (
        watch_timer_en == main_osc_run && watchdog_one_en == main_osc_run &&
            watchdog_two_en == periph_clk_en
    ) else $error("timer clock gates wrong");
endmodule : clk_ctrl_monitor

bind clock_gating_pll_control clk_ctrl_monitor #(
    .OSC_WAIT_CYCLES(OSC_WAIT_CYCLES)
) i_clk_ctrl_monitor (
    .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .halt_req(halt_req),
    .idle_req(idle_req), .stop_req(stop_req), .wake_req(wake_req),
    .main_osc_run(main_osc_run), .cpu_clk_en(cpu_clk_en),
    .sys_clk_en(sys_clk_en), .periph_clk_en(periph_clk_en),
    .watch_timer_en(watch_timer_en), .watchdog_one_en(watchdog_one_en),
    .watchdog_two_en(watchdog_two_en), .multiplier_run(multiplier_run),
    .multiplier_select(multiplier_select), .mult_factor(mult_factor),
    .clock_output_pin_oe(clock_output_pin_oe),
    .clock_source_status(clock_source_status)
);

// ==== sim/osc_partner.sv ====
// model of the oscillator side: subclock source and clock pin wire
`timescale 1ns/10ps
module osc_partner (
    // clock
    input  wire logic clk_sys,
    // pin drive from the block
    input  wire logic pin_o,
    input  wire logic pin_oe,
    // levels toward the block
    output logic      subclock_in,
    output logic      pin_level
);
    logic float_pat = 1'b0;
    // ----------------------------------------
    // subclock crystal runs free, unrelated phase
    // ----------------------------------------
    initial begin
        subclock_in = 1'b0;
        #37;
        forever #1525 subclock_in = ~subclock_in;
    end
    // undriven pin has no keeper: show a changing level
    always @(posedge clk_sys) begin
        float_pat <= ~float_pat;
    end
    assign pin_level = pin_oe ? pin_o : float_pat;
endmodule : osc_partner

// ==== sim/clock_gating_pll_control_tb.sv ====
// self-checking bench for the clock gating and multiplier control block
`timescale 1ns/10ps
module clock_gating_pll_control_tb;
    import clk_ctrl_pkg::*;
    localparam int WAIT = 20;
    logic       clk_sys, resetn, reg_wr, reg_rd, pin_i, pin_o, pin_oe;
    reg_addr_t  reg_addr;
    reg_byte_t  reg_wdata, reg_rdata, rv;
    logic [3:0] req, gv;
    logic       osc_run, cpu_en, sys_en, per_en, sub_in, m_run, m_sel, stat;
    logic [2:0] m_fac, sel;
    logic [1:0] fb;
    int         err_count, samples_checked, seed, n, k;
    assign gv = {osc_run, cpu_en, sys_en, per_en};
    clock_gating_pll_control #(.OSC_WAIT_CYCLES(WAIT))
    i_clock_gating_pll_control (
        .clk_sys(clk_sys), .resetn(resetn), .ce(1'b1), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .halt_req(req[0]), .idle_req(req[1]),
        .stop_req(req[2]), .wake_req(req[3]), .subclock_in(sub_in),
        .main_osc_run(osc_run), .main_feedback_cut(fb[0]),
        .sub_feedback_cut(fb[1]),
        .cpu_clk_en(cpu_en), .sys_clk_en(sys_en), .periph_clk_en(per_en),
        .watch_timer_en(), .watchdog_one_en(), .watchdog_two_en(),
        .multiplier_run(m_run), .multiplier_select(m_sel),
        .mult_factor(m_fac), .clock_output_pin_i(pin_i),
        .clock_output_pin_o(pin_o), .clock_output_pin_oe(pin_oe),
        .clock_source_status(stat));
    osc_partner i_osc_partner (.clk_sys(clk_sys), .pin_o(pin_o),
        .pin_oe(pin_oe), .subclock_in(sub_in), .pin_level(pin_i));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic reg_byte_t half_of(input logic [2:0] s);
        return 8'h01 << ((s > 3'h5) ? 3'h5 : s);
    endfunction : half_of
    task chk(input string nm, input reg_byte_t e, input reg_byte_t g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task cyc(input int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask : cyc
    task wr(input reg_addr_t a, input reg_byte_t d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task rd(input reg_addr_t a, input reg_byte_t e, input string nm);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(nm, e, reg_rdata);
    endtask : rd
    task pulse(input int i);
        @(posedge clk_sys);
        req <= 4'(1 << i);
        @(posedge clk_sys);
        req <= 4'h0;
        #1;
    endtask : pulse
    task gates(input logic [3:0] e);
        chk("gates", {4'h0, e}, {4'h0, gv});
    endtask : gates
    task bit1(input string nm, input logic e, input logic g);
        chk(nm, {7'h0, e}, {7'h0, g});
    endtask : bit1
    task half_period(input reg_byte_t e);
        logic last;
        repeat (2) begin
            last = pin_o;
            for (n = 0; n < 300 && pin_o === last; n++) @(negedge clk_sys);
        end
        last = pin_o;
        for (n = 0; n < 300 && pin_o === last; n++) @(negedge clk_sys);
        chk("half period", e, 8'(n));
    endtask : half_period
    task wait_stat(input logic v);
        for (k = 0; k < 400 && stat !== v; k++) cyc(1);
        bit1("source status", v, stat);
    endtask : wait_stat
    task tend(input string nm);
        $display("test %s done", nm);
    endtask : tend
    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #2000000;
        err_count++;
        $display("watchdog expired");
        wrap_up();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        seed = 32'hf40eceef;
        err_count = 0;
        samples_checked = 0;
        resetn = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        req = 4'h0;
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        #1;
        gates(4'h0);
        bit1("pin oe", 1'b0, pin_oe);
        rd(4'h0, 8'h03, "proc clk reset");
        rd(4'h1, 8'h01, "mult ctrl reset");
        rd(4'h5, 8'h00, "unmapped read");
        wr(4'h2, 8'h01);
        cyc(2);
        bit1("pin oe in wait", 1'b0, pin_oe);
        for (k = 0; k < 100 && sys_en !== 1'b1; k++) cyc(1);
        cyc(2);
        gates(4'hF);
        tend("reset");
        for (int s = 0; s < 7; s++) begin
            sel = (s == 6) ? 3'($unsigned($random(seed)) % 6) : 3'(s);
            wr(4'h2, 8'h00);
            wr(4'h0, {5'h0, sel});
            wr(4'h2, 8'h01);
            half_period(half_of(sel));
            bit1("pin oe clock", 1'b1, pin_oe);
        end
        pulse(0);
        gates(4'hB);
        half_period(half_of(sel));
        pulse(3);
        gates(4'hF);
        tend("clock output");
        wr(4'h1, 8'h00);
        bit1("multiplier run", 1'b0, m_run);
        pulse(1);
        gates(4'h8);
        cyc(80);
        bit1("pin low idle", 1'b0, pin_o);
        pulse(3);
        pulse(2);
        gates(4'h0);
        pulse(3);
        for (k = 0; k < 100 && sys_en !== 1'b1; k++) cyc(1);
        chk("stop wait", 8'(WAIT + 1), 8'(k));
        tend("standby");
        wr(4'h1, 8'h01);
        chk("factor thru", 8'h01, {5'h0, m_fac});
        cyc(2000);
        rv = {4'h0, 2'($random(seed)), 2'b11};
        wr(4'h1, rv);
        chk("factor pll", 8'h04, {5'h0, m_fac});
        rd(4'h1, rv, "mult ctrl");
        wr(4'h1, {rv[7:2], 2'b01});
        chk("factor back", 8'h01, {5'h0, m_fac});
        cyc(8);
        wr(4'h1, 8'h00);
        tend("multiplier");
        wr(4'h0, 8'h2B);
        chk("feedback cut", 8'h01, {6'h0, fb});
        wait_stat(1'b1);
        rd(4'h0, 8'h3B, "status set");
        gates(4'hF);
        wr(4'h0, 8'h6B);
        cyc(2);
        gates(4'h6);
        pulse(1);
        gates(4'h0);
        pulse(3);
        gates(4'h6);
        wr(4'h0, 8'h2B);
        cyc(2);
        gates(4'hF);
        wr(4'h0, 8'h23);
        wait_stat(1'b0);
        wr(4'h0, 8'h53);
        cyc(2);
        bit1("osc on main", 1'b1, osc_run);
        rd(4'h0, 8'h43, "status read only");
        wr(4'h0, 8'h03);
        tend("subclock");
        wr(4'h2, 8'h06);
        cyc(5);
        bit1("port drive", 1'b1, pin_o);
        rd(4'h3, 8'h01, "port input");
        wr(4'h2, 8'h02);
        cyc(2);
        bit1("port float", 1'b0, pin_oe);
        tend("port");
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(4'h1, 8'h01, "mult ctrl rereset");
        tend("second reset");
        wrap_up();
    end
endmodule : clock_gating_pll_control_tb
